// file: sfp_flash.sv
`timescale 1ns/1ns
// Behaviour
// (R1) Host sets the write enable latch before any status write.
// (R2) Status write updates lock, quad enable, block bits; never latch or busy.
// (R3) Host sends opcode, status byte, optional configuration byte, then deselects.
// (R4) Status write executes only after exactly 8 or 16 data bits.
// (R5) Valid status write starts timed cycle; busy shown, then busy and latch clear.
// (R6) Lock bit set with protect pin low refuses every status write; the code accepts one while quad enable or four-wire mode is set.
// (R7) Otherwise write allow sets latch and lock and block bits are writable.
// (R8) Hardware protection holds whenever lock is set and pin low, any order; the code drops it while quad enable or four-wire mode is set.
// (R9) Hardware protection ends only by driving the protect pin high; the code also ends it on four-wire mode high or on reset.
// (R10) Four-wire mode or quad enable disables hardware protection.
// (R11) Block bits and top/bottom bit select the area refused to program/erase.
// (R12) Host keeps protect pin high until a locked status write finishes.
// (R13) Default 24-bit addresses; enter command sets wide flag, 32-bit addresses.
// (R14) Exit command or reset clears wide flag, back to 24-bit.
// (R15) Wide mode changes only address length; id and table reads stay narrow.
// (R16) Wide mode commands are a bare opcode frame.
// (R17) Address sampled on rising clock, data shifted out on falling clock.
// (R18) Read address increments per byte, wraps to zero past the top.
// (R19) Read streams data after the address until deselect at any time.
// (R20) Fast read inserts dummy cycles before data, 8 by default.
// (R21) Fast read dummy count follows configuration dummy field.
// (R22) Reads are refused while a timed cycle runs, cycle undisturbed.
// (R23) Dummy field codes 00 and 10 give 8, 01 gives 6, 11 gives 10.
// (R24) Wide flag is volatile and zero after power-up.
// (R25) First eight bits after select are the opcode, MSB first, mode 0.
module sfp_flash #(
   parameter int ADDR_W = 26,
   parameter int STATUS_NS = sfp_pkg::STATUS_CYCLE_NS
) (
   // System
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Serial link
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe,
   // Protection pins
   input wire logic i_wp_n,
   input wire logic i_four_wire_mode,
   // Region check and state
   input wire logic [31:0] i_chk_addr,
   output logic o_chk_denied,
   output logic [7:0] o_status,
   output logic [7:0] o_config
);
   localparam int CYC_RAW = (STATUS_NS + sfp_pkg::CLK_NS - 1) / sfp_pkg::CLK_NS;
   localparam logic [31:0] STATUS_CYC = 32'(CYC_RAW < 1 ? 1 : CYC_RAW);
   localparam logic [31:0] AMASK = 32'((64'h1 << ADDR_W) - 64'h1);

   if (ADDR_W < 17 || ADDR_W > 32) begin : g_bad_width
      $error("ADDR_W must be 17 to 32");
   end

   function automatic logic [6:0] dummy_of(input logic [1:0] dc);
      unique case (dc)
         sfp_pkg::DC_SHORT: dummy_of = sfp_pkg::DUMMY_SHORT; // R23
         sfp_pkg::DC_LONG: dummy_of = sfp_pkg::DUMMY_LONG; // R23
         default: dummy_of = sfp_pkg::DUMMY_DEF; // R23
      endcase
   endfunction : dummy_of

   // Array contents are a fixed address pattern; no program path exists
   function automatic logic [7:0] mem_byte(input logic [31:0] a);
      mem_byte = a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24];
   endfunction : mem_byte

   function automatic logic prot_hit(input logic [31:0] a, input logic [3:0] bp,
                                     input logic tb);
      logic [31:0] blk;
      logic [31:0] tot;
      logic [31:0] n;
      blk = (a & AMASK) >> sfp_pkg::BLK_SHIFT;
      tot = 32'h1 << (ADDR_W - sfp_pkg::BLK_SHIFT);
      n = (bp == 4'h0) ? 32'h0 : (32'h1 << (bp - 4'h1));
      if (n > tot) n = tot;
      prot_hit = tb ? (blk < n) : (blk >= tot - n);
   endfunction : prot_hit

   sfp_pkg::sfp_core_s c_reg;
   sfp_pkg::sfp_core_s c_next;
   sfp_pkg::sfp_link_s l_reg;
   sfp_pkg::sfp_link_s l_next;
   logic first_reg;
   logic lrst;
   logic fe;
   logic hardware_protection_mode;
   logic sw_len;

   // Link resets whenever deselected so a torn frame leaves no output drive
   assign lrst = i_cs_n | ~i_rst_n;

   // ---------------- Link domain ----------------
   always_ff @(posedge i_sclk or posedge lrst) begin
      if (lrst) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   always_comb begin
      logic [6:0] cnt_v;
      logic [6:0] al;
      logic [6:0] start;
      logic [31:0] a;
      logic rd;
      al = sfp_pkg::AL_NARROW;
      start = sfp_pkg::OPC_BITS;
      a = 32'h0;
      rd = 1'b0;
      l_next = l_reg;
      cnt_v = first_reg ? 7'h00 : l_reg.cnt;
      // Level crossings of busy, wide flag and dummy field
      l_next.sy1 = {c_reg.stat.write_in_progress_flag, c_reg.cfg.wide_address_flag,
                    c_reg.cfg.dc};
      l_next.sy2 = l_reg.sy1;
      l_next.seq = first_reg ? ~l_reg.seq : l_reg.seq;
      l_next.cnt = (cnt_v == sfp_pkg::CNT_MAX) ? cnt_v : cnt_v + 7'h01;
      l_next.sh = {l_reg.sh[6:0], i_si}; // R17
      if (first_reg) l_next.active = 1'b0;
      if (cnt_v == sfp_pkg::OPC_BITS - 7'h01) l_next.op = {l_reg.sh[6:0], i_si}; // R25
      if (cnt_v == sfp_pkg::SW_ONE_BYTE - 7'h01) l_next.b1 = {l_reg.sh[6:0], i_si}; // R3
      if (cnt_v == sfp_pkg::SW_TWO_BYTE - 7'h01) l_next.b2 = {l_reg.sh[6:0], i_si}; // R3
      al = l_reg.sy2[2] ? sfp_pkg::AL_WIDE : sfp_pkg::AL_NARROW; // R13 R15
      if (cnt_v >= sfp_pkg::OPC_BITS && cnt_v < sfp_pkg::OPC_BITS + al) begin
         l_next.addr = {l_reg.addr[30:0], i_si}; // R17
      end
      rd = (l_reg.op == sfp_pkg::OP_READ) || (l_reg.op == sfp_pkg::OP_FAST_READ);
      start = sfp_pkg::OPC_BITS + al;
      if (l_reg.op == sfp_pkg::OP_FAST_READ) begin
         start = start + dummy_of(l_reg.sy2[1:0]); // R20 R21
      end
      a = 32'h0;
      if (!first_reg && l_next.cnt == start && rd && !l_reg.sy2[3]) begin // R22
         a = l_reg.sy2[2] ? l_next.addr : {8'h00, l_next.addr[23:0]};
         a = a & AMASK;
         l_next.addr = a;
         l_next.obyte = mem_byte(a); // R19
         l_next.obit = 3'h0;
         l_next.active = 1'b1;
      end else if (l_reg.active && !first_reg) begin
         if (l_reg.obit == 3'h7) begin
            a = (l_reg.addr + 32'h1) & AMASK; // R18
            l_next.addr = a;
            l_next.obyte = mem_byte(a);
            l_next.obit = 3'h0;
         end else begin
            l_next.obit = l_reg.obit + 3'h1;
         end
      end
   end

   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   // Data leaves on the falling edge so the host samples it mid-bit
   always_ff @(negedge i_sclk or posedge lrst) begin
      if (lrst) begin
         o_so <= 1'b0;
         o_so_oe <= 1'b0;
      end else begin
         o_so <= l_reg.obyte[3'h7 - l_reg.obit]; // R17
         o_so_oe <= l_reg.active; // R19
      end
   end

   // ---------------- Core domain ----------------
   // Frame fields are read only after select has risen, when the link clock
   // is still, so they are stable; seq rejects frames with no clock at all.
   assign fe = c_reg.cs[1] & ~c_reg.cs[2] & (l_reg.seq != c_reg.seen);
   assign hardware_protection_mode = c_reg.stat.status_lock_bit & ~c_reg.pins[1] // R8 R9
                & ~c_reg.stat.quad_enable_bit & ~c_reg.pins[3]; // R10
   assign sw_len = (l_reg.cnt == sfp_pkg::SW_ONE_BYTE)
                   || (l_reg.cnt == sfp_pkg::SW_TWO_BYTE); // R4

   always_comb begin
      c_next = c_reg;
      c_next.cs = {c_reg.cs[1:0], i_cs_n};
      c_next.pins = {c_reg.pins[2], i_four_wire_mode, c_reg.pins[0], i_wp_n};
      c_next.deny = prot_hit(i_chk_addr, c_reg.stat.bp, c_reg.cfg.tb); // R11
      if (fe) c_next.seen = l_reg.seq;
      if (fe && l_reg.cnt == sfp_pkg::OPC_BITS) begin // R16
         if (l_reg.op == sfp_pkg::OP_ENTER_WIDE) c_next.cfg.wide_address_flag = 1'b1; // R13
         if (l_reg.op == sfp_pkg::OP_EXIT_WIDE) c_next.cfg.wide_address_flag = 1'b0; // R14
      end
      unique case (c_reg.st)
         sfp_pkg::ST_IDLE: begin
            if (fe && l_reg.cnt == sfp_pkg::OPC_BITS
                && l_reg.op == sfp_pkg::OP_WRITE_ALLOW) begin
               c_next.stat.write_enable_latch = 1'b1; // R7
            end
            if (fe && l_reg.op == sfp_pkg::OP_STATUS_WRITE && sw_len // R4
                && c_reg.stat.write_enable_latch && !hardware_protection_mode) begin // R1 R6 R8
               c_next.stat.status_lock_bit = l_reg.b1[7]; // R2 R7
               c_next.stat.quad_enable_bit = l_reg.b1[6]; // R2
               c_next.stat.bp = l_reg.b1[5:2]; // R2
               if (l_reg.cnt == sfp_pkg::SW_TWO_BYTE) begin
                  c_next.cfg.dc = l_reg.b2[7:6]; // R21
                  c_next.cfg.pbe = l_reg.b2[4];
                  // Top/bottom is one-time: it can only be set
                  c_next.cfg.tb = c_reg.cfg.tb | l_reg.b2[3];
                  c_next.cfg.ods = l_reg.b2[2:0];
               end
               c_next.stat.write_in_progress_flag = 1'b1; // R5
               c_next.tmr = 32'h0;
               c_next.st = sfp_pkg::ST_BUSY;
            end
         end
         sfp_pkg::ST_BUSY: begin
            c_next.tmr = c_reg.tmr + 32'h1;
            if (c_reg.tmr >= STATUS_CYC - 32'h1) begin
               c_next.stat.write_in_progress_flag = 1'b0; // R5
               c_next.stat.write_enable_latch = 1'b0; // R5
               c_next.st = sfp_pkg::ST_IDLE;
            end
         end
         default: c_next.st = sfp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         c_reg <= '0;
         c_reg.st <= sfp_pkg::ST_IDLE;
         c_reg.cs <= 3'h7;
         c_reg.pins <= 4'h3;
         c_reg.stat <= sfp_pkg::STATUS_RST;
         c_reg.cfg <= sfp_pkg::CONFIG_RST; // R14 R24
      end else begin
         c_reg <= c_next;
      end
   end

   assign o_status = c_reg.stat;
   assign o_config = c_reg.cfg;
   assign o_chk_denied = c_reg.deny;

   // ---------------- Checks ----------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_busy_cause: assert property ($rose(c_reg.stat.write_in_progress_flag) |-> $past(fe)) // R5
      else $error("busy rose without a frame end");
   a_latch_at_done: assert property ($fell(c_reg.stat.write_in_progress_flag) // R5
      |-> !c_reg.stat.write_enable_latch)
      else $error("latch still set after cycle");
   a_latch_kept: assert property ($rose(c_reg.stat.write_in_progress_flag) // R2
      |-> c_reg.stat.write_enable_latch)
      else $error("status data altered the latch");
   a_hpm_refuse: assert property (fe && hardware_protection_mode |=> !$rose(c_reg.stat.write_in_progress_flag)) // R8
      else $error("status write taken under hardware protection");
   a_bad_length: assert property (fe && !sw_len // R4
      |=> !$rose(c_reg.stat.write_in_progress_flag))
      else $error("status write taken at wrong length");
   a_quad_unlock: assert property (fe && c_reg.st == sfp_pkg::ST_IDLE // R10
      && l_reg.op == sfp_pkg::OP_STATUS_WRITE && sw_len && c_reg.stat.write_enable_latch
      && (c_reg.stat.quad_enable_bit || c_reg.pins[3])
      |=> c_reg.stat.write_in_progress_flag)
      else $error("quad enable did not lift hardware protection");
   a_spm_write: assert property (fe && c_reg.st == sfp_pkg::ST_IDLE // R7
      && l_reg.op == sfp_pkg::OP_STATUS_WRITE && sw_len && c_reg.stat.write_enable_latch
      && !hardware_protection_mode |=> c_reg.stat.write_in_progress_flag)
      else $error("status write refused outside hardware protection");
   a_latch_set: assert property (fe && c_reg.st == sfp_pkg::ST_IDLE // R7
      && l_reg.cnt == sfp_pkg::OPC_BITS && l_reg.op == sfp_pkg::OP_WRITE_ALLOW
      |=> c_reg.stat.write_enable_latch)
      else $error("write allow did not set the latch");
   // Busy span is judged on the cycle counter, so a short or long cycle shows here
   a_cycle_time: assert property ($fell(c_reg.stat.write_in_progress_flag) // R5
      |-> c_reg.tmr == STATUS_CYC)
      else $error("timed cycle ended early or late");
   a_busy_shown: assert property (c_reg.st == sfp_pkg::ST_BUSY // R5
      |-> c_reg.stat.write_in_progress_flag)
      else $error("busy flag low during timed cycle");
   a_wide_enter: assert property (fe && l_reg.cnt == sfp_pkg::OPC_BITS // R13
      && l_reg.op == sfp_pkg::OP_ENTER_WIDE |=> c_reg.cfg.wide_address_flag)
      else $error("wide flag not set");
   a_wide_exit: assert property (fe && l_reg.cnt == sfp_pkg::OPC_BITS // R14
      && l_reg.op == sfp_pkg::OP_EXIT_WIDE |=> !c_reg.cfg.wide_address_flag)
      else $error("wide flag not cleared");
   a_read_refused: assert property (@(posedge i_sclk) disable iff (!i_rst_n) // R22
      $rose(l_reg.active) |-> !$past(l_reg.sy2[3]))
      else $error("read started while busy");
   a_addr_wrap: assert property (@(posedge i_sclk) disable iff (!i_rst_n) // R18
      l_reg.active && l_reg.obit == 3'h7 && l_reg.addr == AMASK
      |=> first_reg || l_reg.addr == 32'h0)
      else $error("address did not wrap to zero");

   c_status_write: cover property ($rose(c_reg.stat.write_in_progress_flag));
   c_wide_on: cover property ($rose(c_reg.cfg.wide_address_flag));
   c_hpm_block: cover property (fe && hardware_protection_mode && l_reg.op == sfp_pkg::OP_STATUS_WRITE);
   c_read_run: cover property (@(posedge i_sclk) disable iff (!i_rst_n)
      l_reg.active && l_reg.op == sfp_pkg::OP_FAST_READ);
endmodule : sfp_flash

// file: sfp_pkg.sv
package sfp_pkg;
   // Command codes
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_WRITE_ALLOW = 8'h06;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
   localparam logic [7:0] OP_EXIT_WIDE = 8'he9;
   // Lengths in serial bits; status write frame lengths include the opcode
   localparam logic [6:0] OPC_BITS = 7'h08;
   localparam logic [6:0] SW_ONE_BYTE = 7'h10;
   localparam logic [6:0] SW_TWO_BYTE = 7'h18;
   localparam logic [6:0] CNT_MAX = 7'h7f;
   localparam logic [6:0] AL_NARROW = 7'h18;
   localparam logic [6:0] AL_WIDE = 7'h20;
   localparam logic [6:0] DUMMY_SHORT = 7'h06;
   localparam logic [6:0] DUMMY_DEF = 7'h08;
   localparam logic [6:0] DUMMY_LONG = 7'h0a;
   localparam logic [1:0] DC_SHORT = 2'h1;
   localparam logic [1:0] DC_LONG = 2'h3;
   // Protection granule and timing
   localparam int BLK_SHIFT = 16;
   localparam int CLK_NS = 40;
   localparam int STATUS_CYCLE_NS = 40000;
   // Field layouts
   typedef struct packed {
      logic status_lock_bit;
      logic quad_enable_bit;
      logic [3:0] bp;
      logic write_enable_latch;
      logic write_in_progress_flag;
   } sfp_status_s;
   typedef struct packed {
      logic [1:0] dc;
      logic wide_address_flag;
      logic pbe;
      logic tb;
      logic [2:0] ods;
   } sfp_config_s;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CONFIG_RST = 8'h07;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} sfp_st_e;
   typedef struct packed {
      sfp_st_e st;
      logic [2:0] cs;
      logic [3:0] pins;
      logic seen;
      sfp_status_s stat;
      sfp_config_s cfg;
      logic [31:0] tmr;
      logic deny;
   } sfp_core_s;
   typedef struct packed {
      logic [6:0] cnt;
      logic seq;
      logic [7:0] op;
      logic [7:0] sh;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [31:0] addr;
      logic [7:0] obyte;
      logic [2:0] obit;
      logic active;
      logic [3:0] sy1;
      logic [3:0] sy2;
   } sfp_link_s;
endpackage : sfp_pkg

// file: sfp_host_model.sv
`timescale 1ns/1ns
module sfp_host_model (
   // Serial link
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_si,
   input wire logic i_so,
   input wire logic i_so_oe
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b1;
   end
   // Mode 0 frame of 30 ns bits; the clock stands low between frames
   task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                        output logic [63:0] rx, output logic oe_seen);
      rx = '0;
      oe_seen = 1'b0;
      o_cs_n = 1'b0;
      #15;
      for (int i = 0; i < ntx + nrx; i++) begin
         // Past the command, si toggles so a stale level is never mistaken for data
         o_si = (i < ntx) ? tx[63 - i] : ~o_si;
         #15 o_sclk = 1'b1;
         if (i >= ntx) begin
            rx = {rx[62:0], i_so};
            oe_seen = oe_seen | i_so_oe;
         end
         #15 o_sclk = 1'b0;
      end
      #15 o_cs_n = 1'b1;
      o_si = ~o_si;
      // Deselect gap well above the three core cycles the device needs
      #200;
   endtask : frame
endmodule : sfp_host_model

// file: test_serial_flash_status_protect_read.sv
`timescale 1ns/1ns
module test_serial_flash_status_protect_read;
   logic i_clk, i_rst_n, sclk, cs_n, si, so, so_oe, wp_n, four_wire, denied, oe;
   logic [31:0] chk_addr;
   logic [7:0] status, cfg_q;
   logic [63:0] rx;
   int error_cnt, comparisons;
   int dl[4] = '{8, 6, 8, 10};
   sfp_flash #(.ADDR_W(26), .STATUS_NS(4000)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_wp_n(wp_n),
      .i_four_wire_mode(four_wire), .i_chk_addr(chk_addr), .o_chk_denied(denied),
      .o_status(status), .o_config(cfg_q));
   sfp_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so),
      .i_so_oe(so_oe));
   always #20 i_clk = ~i_clk;
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic cmd(input logic [7:0] op);
      host.frame({op, 56'h0}, 8, 0, rx, oe);
      @(negedge i_clk);
   endtask : cmd
   task automatic wr_status(input logic [15:0] d, input int nbits);
      cmd(sfp_pkg::OP_WRITE_ALLOW);
      host.frame({sfp_pkg::OP_STATUS_WRITE, d, 40'h0}, 8 + nbits, 0, rx, oe);
      @(negedge i_clk);
   endtask : wr_status
   task automatic wait_idle;
      int n;
      n = 0;
      while (status[0] !== 1'b0 && n < 300) begin
         @(negedge i_clk);
         n++;
      end
   endtask : wait_idle
   task automatic rd(input logic [7:0] op, input logic [31:0] a, input int alen,
                     input int dmy);
      host.frame({op, (alen == 32) ? a : {a[23:0], 8'h0}, 24'h0}, 8 + alen + dmy, 16, rx, oe);
      @(negedge i_clk);
   endtask : rd
   task automatic set_pins(input logic wp, input logic fw);
      @(negedge i_clk);
      wp_n = wp;
      four_wire = fw;
      repeat (4) @(negedge i_clk);
   endtask : set_pins
   task automatic chk_at(input logic [31:0] a, input logic e);
      @(negedge i_clk);
      chk_addr = a;
      repeat (2) @(negedge i_clk);
      chk(denied, e);
   endtask : chk_at
   task automatic t_status_write;
      host.frame({sfp_pkg::OP_STATUS_WRITE, 8'hbc, 48'h0}, 16, 0, rx, oe);
      repeat (8) @(negedge i_clk);
      chk(status, 8'h00);
      wr_status(16'hbc00, 8);
      chk(status, 8'hbf);
      wait_idle();
      chk(status, 8'hbc);
   endtask : t_status_write
   task automatic t_protect;
      set_pins(1'b0, 1'b0);
      wr_status(16'h0000, 8);
      repeat (8) @(negedge i_clk);
      chk(status[7:2], 6'h2f);
      set_pins(1'b0, 1'b1);
      wr_status(16'hc000, 8);
      wait_idle();
      chk(status, 8'hc0);
      set_pins(1'b0, 1'b0);
      wr_status(16'h8400, 8);
      wait_idle();
      chk(status, 8'h84);
      wr_status(16'h0400, 8);
      repeat (8) @(negedge i_clk);
      chk(status[7:2], 6'h21);
      set_pins(1'b1, 1'b0);
      wr_status(16'h0400, 8);
      // Pin stays high until the cycle is over
      wait_idle();
      chk(status, 8'h04);
   endtask : t_protect
   task automatic t_length;
      int nb[3] = '{4, 12, 9};
      for (int k = 0; k < 3; k++) begin
         wr_status(16'h3cff, nb[k]);
         repeat (8) @(negedge i_clk);
         chk({status[7:2], status[0]}, 7'h02);
      end
   endtask : t_length
   task automatic t_dummy;
      for (int k = 0; k < 4; k++) begin
         wr_status({8'h04, k[1:0], 6'h07}, 16);
         wait_idle();
         chk(cfg_q, {k[1:0], 6'h07});
         rd(sfp_pkg::OP_FAST_READ, 32'h00123456, 24, dl[k]);
         chk({oe, rx[15:0]}, 17'h17071);
      end
   endtask : t_dummy
   task automatic t_wide;
      rd(sfp_pkg::OP_READ, 32'h00123456, 24, 0);
      chk({oe, rx[15:0]}, 17'h17071);
      cmd(sfp_pkg::OP_ENTER_WIDE);
      chk(cfg_q[5], 1'b1);
      rd(sfp_pkg::OP_READ, 32'h03ffffff, 32, 0);
      chk(rx[15:0], 16'hfc00);
      cmd(sfp_pkg::OP_EXIT_WIDE);
      chk(cfg_q[5], 1'b0);
   endtask : t_wide
   task automatic t_busy_read;
      wr_status(16'h0400, 8);
      rd(sfp_pkg::OP_READ, 32'h00123456, 24, 0);
      chk({oe, status[0]}, 2'b01);
      wait_idle();
      chk(status, 8'h04);
      cmd(sfp_pkg::OP_ENTER_WIDE);
      chk(cfg_q[5], 1'b1);
      @(negedge i_clk);
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_clk);
      i_rst_n = 1'b1;
      @(negedge i_clk);
      chk(cfg_q[5], 1'b0);
   endtask : t_busy_read
   initial begin
      i_clk = 1'b0;
      i_rst_n = 1'b0;
      wp_n = 1'b1;
      four_wire = 1'b0;
      chk_addr = 32'h0;
      error_cnt = 0;
      comparisons = 0;
      repeat (2) @(negedge i_clk);
      i_rst_n = 1'b1;
      @(negedge i_clk);
      chk({status, cfg_q}, 16'h0007);
      t_status_write();
      t_protect();
      chk_at(32'h03ffffff, 1'b1);
      chk_at(32'h03ff0000, 1'b1);
      chk_at(32'h03feffff, 1'b0);
      t_length();
      t_dummy();
      t_wide();
      t_busy_read();
      report_and_stop();
   end
   initial begin
      // Whole run is near 70 us; this leaves ample margin
      #600000;
      error_cnt++;
      report_and_stop();
   end
endmodule : test_serial_flash_status_protect_read
